// *** src/srsp_defs.vh ***
// constants for the serial register slave port
`ifndef SRSP_DEFS_VH
`define SRSP_DEFS_VH

// register map
`define SRSP_ADDR_CFG      15'h0000
`define SRSP_ADDR_SCRATCH  15'h0009
`define SRSP_ADDR_LAST     15'h0009
`define SRSP_ADDR_ONE      15'h0001

// reset values
`define SRSP_CFG_RST       8'h00
`define SRSP_SCRATCH_RST   8'h00
`define SRSP_ZERO_BYTE     8'h00

// config field positions
`define SRSP_CFG_SEP       4
`define SRSP_CFG_UP        5
`define SRSP_CFG_LSB       6
`define SRSP_CFG_STREAM    7

// bit counter start, step and end values
`define SRSP_CNT_ZERO      4'h0
`define SRSP_CNT_ONE       4'h1
`define SRSP_INSTR_LAST    4'hf
`define SRSP_BYTE_LAST     4'h7

`endif

// *** src/srsp_slave.v ***
// serial register slave port: sampled link, instruction decode, registers
`timescale 1ns/10ps
`include "srsp_defs.vh"

module srsp_slave
(
  input  wire I_CLK_SYS,            // system clock, 125 mhz
  input  wire I_RST,                // async reset, active high
  input  wire I_SCLK,               // serial clock from master
  input  wire I_CHIP_SELECT_N,      // frame select, active low
  input  wire I_SDIO,               // shared data line, input side
  output wire O_SDIO,               // shared data line, output side
  output wire O_SDIO_OE,            // shared data line drive enable
  output wire O_SERIAL_DATA_OUT,    // 4-wire read data
  output wire O_SERIAL_DATA_OUT_OE, // 4-wire read data drive enable
  output wire O_SEPARATE_LINES_SEL  // current wiring mode, 1 = 4-wire
);

  // frame states
  localparam ST_INSTR = 2'b00;
  localparam ST_DATA  = 2'b01;
  localparam ST_HOLD  = 2'b10;

  reg        cs_s1_q;
  reg        cs_s2_q;
  reg        sclk_s1_q;
  reg        sclk_s2_q;
  reg        sclk_s3_q;
  reg        sdi_s1_q;
  reg        sdi_s2_q;
  reg [1:0]  state_q;
  reg [3:0]  cnt_q;
  reg [15:0] instr_q;
  reg [7:0]  rx_q;
  reg [7:0]  tx_q;
  reg [14:0] addr_q;
  reg        rw_q;
  reg        dout_q;
  reg        sdio_oe_q;
  reg        sdo_oe_q;
  reg [7:0]  cfg_q;
  reg [7:0]  scratch_q;

  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_act;
  wire        high_bit_first_sel;
  wire        separate_lines_sel;
  wire        addr_step_up_sel;
  wire        multibyte_enable;
  wire [15:0] instr_d;
  wire [7:0]  rx_d;
  wire [14:0] addr_d;
  wire [14:0] start_addr;
  wire        instr_done;
  wire        byte_done;
  wire        wr_fire;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // two flops per pin; the third sclk flop only serves edge detection
  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      cs_s1_q   <= 1'h1;
      cs_s2_q   <= 1'h1;
      sclk_s1_q <= 1'h0;
      sclk_s2_q <= 1'h0;
      sclk_s3_q <= 1'h0;
      sdi_s1_q  <= 1'h0;
      sdi_s2_q  <= 1'h0;
    end
    else
    begin
      cs_s1_q   <= I_CHIP_SELECT_N;
      cs_s2_q   <= cs_s1_q;
      sclk_s1_q <= I_SCLK;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdi_s1_q  <= I_SDIO;
      sdi_s2_q  <= sdi_s1_q;
    end
  end

  // edges seen after synchronising; data shares the same delay
  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
  assign cs_act    = ~cs_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // configuration fields

  // settings apply live, so a config write steers the next byte
  assign separate_lines_sel = cfg_q[`SRSP_CFG_SEP];
  assign addr_step_up_sel   = cfg_q[`SRSP_CFG_UP];
  assign high_bit_first_sel = ~cfg_q[`SRSP_CFG_LSB];
  assign multibyte_enable   = cfg_q[`SRSP_CFG_STREAM];

  //////////////////////////////////////////////////////////////////////////
  // shift paths

  // msb first shifts in at bit 0, lsb first at the top; both orders
  // leave the flag in bit 15 and the address in bits 14:0
  assign instr_d = high_bit_first_sel ?
                   {instr_q[14:0], sdi_s2_q} :
                   {sdi_s2_q, instr_q[15:1]};
  assign rx_d    = high_bit_first_sel ?
                   {rx_q[6:0], sdi_s2_q} :
                   {sdi_s2_q, rx_q[7:1]};

  // bit 15 is the direction flag, the rest the start address
  assign start_addr = instr_d[14:0];

  assign instr_done = (state_q == ST_INSTR) & sclk_rise &
                      (cnt_q == `SRSP_INSTR_LAST);
  assign byte_done  = (state_q == ST_DATA) & sclk_rise &
                      (cnt_q == `SRSP_BYTE_LAST);

  // a write lands only on a whole byte, so a short frame writes nothing
  assign wr_fire = byte_done & ~rw_q & cs_act;

  //////////////////////////////////////////////////////////////////////////
  // address stepping

  // wrap at both ends of the defined map
  assign addr_d = addr_step_up_sel ?
                  ((addr_q == `SRSP_ADDR_LAST) ? `SRSP_ADDR_CFG :
                   addr_q + `SRSP_ADDR_ONE) :
                  ((addr_q == `SRSP_ADDR_CFG) ? `SRSP_ADDR_LAST :
                   addr_q - `SRSP_ADDR_ONE);

  //////////////////////////////////////////////////////////////////////////
  // read mux

  // undefined addresses, 0x00a among them, read as zero
  function [7:0] rd_byte;
    input [14:0] a;
    begin
      if (a == `SRSP_ADDR_CFG)
        rd_byte = cfg_q;
      else if (a == `SRSP_ADDR_SCRATCH)
        rd_byte = scratch_q;
      else
        rd_byte = `SRSP_ZERO_BYTE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register file

  // writes to unmapped addresses fall through and are dropped
  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      cfg_q     <= `SRSP_CFG_RST;
      scratch_q <= `SRSP_SCRATCH_RST;
    end
    else if (wr_fire)
    begin
      if (addr_q == `SRSP_ADDR_CFG)
        cfg_q <= rx_d;
      else if (addr_q == `SRSP_ADDR_SCRATCH)
        scratch_q <= rx_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frame sequencer

  // deselect clears the state, bit count and drive enables, so a half-shifted byte is lost
  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q   <= ST_INSTR;
      cnt_q     <= `SRSP_CNT_ZERO;
      instr_q   <= 16'h0000;
      rx_q      <= `SRSP_ZERO_BYTE;
      tx_q      <= `SRSP_ZERO_BYTE;
      addr_q    <= `SRSP_ADDR_CFG;
      rw_q      <= 1'h0;
      dout_q    <= 1'h0;
      sdio_oe_q <= 1'h0;
      sdo_oe_q  <= 1'h0;
    end
    else if (!cs_act)
    begin
      state_q   <= ST_INSTR;
      cnt_q     <= `SRSP_CNT_ZERO;
      sdio_oe_q <= 1'h0;
      sdo_oe_q  <= 1'h0;
    end
    else
    begin
      case (state_q)
        ST_INSTR:
        begin
          if (sclk_rise)
          begin
            instr_q <= instr_d;
            cnt_q   <= cnt_q + `SRSP_CNT_ONE;
          end
          // the read byte is fetched before the first data falling edge
          if (instr_done)
          begin
            rw_q    <= instr_d[15];
            addr_q  <= start_addr;
            tx_q    <= rd_byte(start_addr);
            cnt_q   <= `SRSP_CNT_ZERO;
            state_q <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (sclk_rise)
          begin
            rx_q  <= rx_d;
            cnt_q <= cnt_q + `SRSP_CNT_ONE;
          end
          // next address is prefetched so streaming reads keep pace
          if (byte_done)
          begin
            cnt_q  <= `SRSP_CNT_ZERO;
            addr_q <= addr_d;
            tx_q   <= rd_byte(addr_d);
            if (!multibyte_enable)
              state_q <= ST_HOLD;
            else
              state_q <= ST_DATA;
          end
          // read data launches on the falling edge
          if (sclk_fall && rw_q)
          begin
            if (high_bit_first_sel)
            begin
              dout_q <= tx_q[7];
              tx_q   <= {tx_q[6:0], 1'h0};
            end
            else
            begin
              dout_q <= tx_q[0];
              tx_q   <= {1'h0, tx_q[7:1]};
            end
            sdio_oe_q <= ~separate_lines_sel;
            sdo_oe_q  <= separate_lines_sel;
          end
        end
        ST_HOLD:
        begin
          // single byte done: release the line after the last bit
          if (sclk_fall)
          begin
            sdio_oe_q <= 1'h0;
            sdo_oe_q  <= 1'h0;
          end
        end
        default:
        begin
          state_q <= ST_INSTR;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // one data flop feeds both lines; only the enables differ by mode
  assign O_SDIO               = dout_q;
  assign O_SDIO_OE            = sdio_oe_q;
  assign O_SERIAL_DATA_OUT    = dout_q;
  assign O_SERIAL_DATA_OUT_OE = sdo_oe_q;
  assign O_SEPARATE_LINES_SEL = cfg_q[`SRSP_CFG_SEP];

endmodule

// *** testbench/srsp_slave_properties.sv ***
// pin-level assertions for the serial register slave port
`timescale 1ns/10ps
module srsp_checker
(
  input wire I_CLK_SYS,            // sys clock
  input wire I_RST,                // reset
  input wire I_SCLK,               // serial clock
  input wire I_CHIP_SELECT_N,      // frame select
  input wire I_SDIO,               // data in
  input wire O_SDIO,               // shared data out
  input wire O_SDIO_OE,            // shared enable
  input wire O_SERIAL_DATA_OUT,    // 4-wire data
  input wire O_SERIAL_DATA_OUT_OE, // 4-wire enable
  input wire O_SEPARATE_LINES_SEL  // wiring mode
);
  // one clock domain, so one default for all
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  //////////////////////////////////////////////
  // six idle samples leave room for the synchroniser
  AST_QUIET_IDLE: assert property (I_CHIP_SELECT_N [*6] |->
    !O_SDIO_OE && !O_SERIAL_DATA_OUT_OE) else $error("drive while idle");
  AST_ONE_LINE_3W: assert property (!O_SEPARATE_LINES_SEL |->
    !O_SERIAL_DATA_OUT_OE) else $error("out line used in 3-wire");
  AST_ONE_LINE_4W: assert property (O_SEPARATE_LINES_SEL |->
    !O_SDIO_OE) else $error("shared line used in 4-wire");
  AST_LAUNCH_LOW: assert property ((O_SDIO_OE || O_SERIAL_DATA_OUT_OE)
    && $changed(O_SDIO) |-> !I_SCLK && !$past(I_SCLK, 2))
    else $error("read data moved outside clock low");
  AST_HOLD_HIGH: assert property (I_SCLK && O_SDIO_OE |->
    $stable(O_SDIO)) else $error("shared data moved while clock high");
  AST_SDO_HOLD: assert property (I_SCLK && O_SERIAL_DATA_OUT_OE |->
    $stable(O_SERIAL_DATA_OUT)) else $error("out data moved, clock high");
  AST_OE_LOW: assert property ($rose(O_SDIO_OE) |->
    !I_CHIP_SELECT_N && !I_SCLK) else $error("drive began badly");
  AST_MODE_IDLE: assert property (I_CHIP_SELECT_N [*6] |=>
    $stable(O_SEPARATE_LINES_SEL)) else $error("mode moved outside frame");
endmodule

bind srsp_slave srsp_checker u_chk (.I_CLK_SYS, .I_RST, .I_SCLK,
  .I_CHIP_SELECT_N, .I_SDIO, .O_SDIO, .O_SDIO_OE, .O_SERIAL_DATA_OUT,
  .O_SERIAL_DATA_OUT_OE, .O_SEPARATE_LINES_SEL);

// *** testbench/srsp_master.sv ***
// bus master model: frames, serial clock and data toward the port
`timescale 1ns/10ps
module srsp_master
(
  input  wire  i_clk,  // system clock
  input  wire  i_sdi,  // read data line in use
  output logic o_sclk, // serial clock, still between frames
  output logic o_cs_n, // chip_select_n
  output logic o_sdo   // data toward the port
);
  //////////////////////////////////////////////
  // idle levels before any frame
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdo  = 1'b0;
  end

  // n bits at 10 sysclk each; a released line toggles, no pull
  task automatic xfer(input logic [47:0] s, input int n, input logic rd,
                      output logic [31:0] c);
    c = '0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_sdo <= (rd && i > 15) ? !o_sdo : s[47-i];
      repeat (5) @(posedge i_clk);
      o_sclk <= 1'b1;
      c = {c[30:0], i_sdi};
      repeat (5) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (5) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_sdo  <= !o_sdo;
    repeat (10) @(posedge i_clk);
  endtask
endmodule

// *** testbench/test_srsp_slave.sv ***
// self-checking bench for the serial register slave port
`timescale 1ns/10ps
module test_srsp_slave;
  logic        clk, rst, four;
  logic        sclk, cs_n, m_sdo, sdio_q, sdio_oe, serial_data_out, sdo_oe, sep;
  int          miscompares, check_count;
  logic [31:0] q;
  // shared line resolved from both parties; 4-wire line floats when off
  wire         sdio_w = sdio_oe ? sdio_q : m_sdo;
  wire         sdo_w  = sdo_oe ? serial_data_out : 1'bz;

  srsp_slave uut (.I_CLK_SYS(clk), .I_RST(rst), .I_SCLK(sclk),
    .I_CHIP_SELECT_N(cs_n), .I_SDIO(sdio_w), .O_SDIO(sdio_q),
    .O_SDIO_OE(sdio_oe), .O_SERIAL_DATA_OUT(serial_data_out),
    .O_SERIAL_DATA_OUT_OE(sdo_oe), .O_SEPARATE_LINES_SEL(sep));
  srsp_master u_mst (.i_clk(clk), .i_sdi(four ? sdo_w : sdio_w),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdo(m_sdo));
  //////////////////////////////////////////////
  // 125 mhz system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one register frame of nb bytes; lsb flips every field on the wire
  task automatic acc(input logic rd, lsb, input logic [14:0] a,
                     input logic [31:0] d, input int nb,
                     output logic [31:0] r);
    logic [15:0] ins;
    logic [47:0] s;
    logic [31:0] c;
    logic [31:0] ds;
    ins = {rd, a};
    ds  = d << (32 - 8 * nb);
    s = {ins, ds};
    // reverse from an untouched copy; an in-place swap folds each byte
    for (int k = 0; k < 48 && lsb; k++)
      s[k] = (k > 31) ? ins[47-k] : ds[(k & ~7) + 7 - k % 8];
    u_mst.xfer(s, 16 + 8 * nb, rd, c);
    for (int k = 0; k < 32 && lsb; k++)
      r[k] = c[(k & ~7) + 7 - k % 8];
    r = (lsb ? r : c) & ~(32'hffffffff << 8 * nb);
  endtask

  // cfg reset value, 3-wire scratch loopback, undefined address
  task automatic t_scratch;
    acc(1, 0, 15'h000, 0, 1, q);
    chk("cfg reset", q, 32'h0);
    acc(0, 0, 15'h009, 32'h5a, 1, q);
    acc(1, 0, 15'h009, 0, 1, q);
    chk("scratch", q, 32'h5a);
    // unmapped stand-in; the reserved 0x00a is kept off the bus
    acc(0, 0, 15'h005, 32'hff, 1, q);
    acc(1, 0, 15'h005, 0, 1, q);
    chk("undefined", q, 32'h0);
  endtask

  // both wiring codes, read back over each line
  task automatic t_wiring;
    acc(0, 0, 15'h000, 32'h3c, 1, q);
    four = 1'b1;
    chk("sel 4w", {31'h0, sep}, 32'h1);
    acc(1, 0, 15'h009, 0, 1, q);
    chk("4w read", q, 32'h5a);
    acc(0, 0, 15'h000, 32'h24, 1, q);
    four = 1'b0;
    chk("sel 3w", {31'h0, sep}, 32'h0);
    acc(1, 0, 15'h009, 0, 1, q);
    chk("3w read", q, 32'h5a);
  endtask

  // streaming down and up across the wrap, then a cut frame
  task automatic t_stream;
    acc(0, 0, 15'h000, 32'h90, 1, q);
    four = 1'b1;
    acc(0, 0, 15'h009, 32'hc3112233, 4, q);
    acc(1, 0, 15'h001, 0, 4, q);
    chk("down", q, 32'h0090c300);
    acc(0, 0, 15'h000, 32'hb0, 1, q);
    acc(1, 0, 15'h009, 0, 3, q);
    chk("up", q, 32'hc3b000);
    u_mst.xfer({1'b0, 15'h009, 32'h0f000000}, 20, 1'b0, q);
    acc(1, 0, 15'h009, 0, 1, q);
    chk("cut frame", q, 32'hc3);
  endtask

  // single byte drops extras; lsb-first order
  task automatic t_lsb;
    acc(0, 0, 15'h000, 32'h24, 1, q);
    four = 1'b0;
    acc(0, 0, 15'h009, 32'h6699, 2, q);
    acc(0, 0, 15'h000, 32'h64, 1, q);
    acc(1, 1, 15'h009, 0, 1, q);
    chk("single", q, 32'h66);
    acc(0, 1, 15'h009, 32'h1e, 1, q);
    acc(1, 1, 15'h009, 0, 1, q);
    chk("lsb data", q, 32'h1e);
    acc(1, 1, 15'h000, 0, 1, q);
    chk("lsb cfg", q, 32'h64);
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog well past the expected 7k cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    test_done;
  end

  // reset, then the scenarios
  initial
  begin
    rst = 1'b1;
    four = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_scratch;
    t_wiring;
    t_stream;
    t_lsb;
    test_done;
  end
endmodule
